// ==== verilog/srwg_guard.sv ====
// Purpose: Guard of system-critical registers against stray writes
// Assumes: Plain register port, read data one cycle after the strobe
// Notes: One access per cycle; internal RAM never reaches this port
//
// How it works
// - Unlock register write-only, reads return zero
// - Protected write only right after unlock
// - Protected write without unlock sets error
// - Other write after unlock sets error
// - Reads keep pending unlock and flag
// - Writing zero or reset clears flag
// - Zero-write to flag after unlock wins
// - Second unlock in a row sets error
// - Status readable, writable byte or bit
// - Status register resets to zero
// - Nine protected registers in the set
// - Raise int_hold while unlock is pending; irq itself is not gated
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "srwg_map.svh"

module srwg_guard
  import srwg_pkg::*;
#(
  parameter int PROT_NUM = `SRWG_PROT_NUM
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [`SRWG_ADDR_W-1:0] bus_addr,
  input wire logic [`SRWG_DATA_W-1:0] bus_wdata,
  input wire logic [`SRWG_DATA_W-1:0] bus_wmask,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [`SRWG_DATA_W-1:0] bus_rdata,
  output logic [PROT_NUM*`SRWG_DATA_W-1:0] prot_value,
  output logic protection_error_flag,
  output logic unlock_pending,
  output logic int_hold,
  output logic irq
);

  localparam int IDX_W = $clog2(PROT_NUM);

  // Address class decode
  function automatic srwg_cls_e decode(input logic [`SRWG_ADDR_W-1:0] a);
    srwg_cls_e c;
    c = SRWG_CLS_OTHER;
    if (a == `SRWG_OFS_UNLOCK)
    begin
      c = SRWG_CLS_UNLOCK;
    end
    else if (a == `SRWG_OFS_SYS)
    begin
      c = SRWG_CLS_SYS;
    end
    else if (a == `SRWG_OFS_IRQ_STAT)
    begin
      c = SRWG_CLS_IRQS;
    end
    else if (a == `SRWG_OFS_IRQ_MASK)
    begin
      c = SRWG_CLS_IRQM;
    end
    else if ((a >= `SRWG_OFS_PROT0) &&
             ({1'b0, a} < ({1'b0, `SRWG_OFS_PROT0} + 9'(PROT_NUM))))
    begin
      c = SRWG_CLS_PROT;
    end
    return c;
  endfunction

  srwg_cls_e cls;
  srwg_lock_e lock;
  srwg_lock_e next_lock;
  logic [IDX_W-1:0] prot_idx;
  logic [`SRWG_DATA_W-1:0] prot_q [PROT_NUM];
  logic [`SRWG_DATA_W-1:0] next_prot [PROT_NUM];
  logic next_err;
  logic [`SRWG_DATA_W-1:0] next_rdata;
  logic [`SRWG_DATA_W-1:0] sys_value;
  logic wr_ok;
  logic err_set;
  logic sys_clr;
  logic [`SRWG_EV_NUM-1:0] events;
  logic [`SRWG_EV_NUM-1:0] irq_stat;
  logic [`SRWG_EV_NUM-1:0] irq_mask;

  assign cls = decode(bus_addr);
  assign prot_idx = IDX_W'(bus_addr - `SRWG_OFS_PROT0);
  assign unlock_pending = (lock == SRWG_ARMED);

  // Hold off interrupt acknowledge until the next store arrives, guarded or not
  assign int_hold = unlock_pending;

  // Status register image, reserved bits read zero
  always_comb
  begin
    sys_value = `SRWG_SYS_RST;
    sys_value[`SRWG_SYS_ERR_BIT] = protection_error_flag;
  end

  // Unlock sequencing
  always_comb
  begin
    next_lock = lock;
    if (bus_wr)
    begin
      case (lock)
        SRWG_LOCKED:
        begin
          if (cls == SRWG_CLS_UNLOCK)
          begin
            next_lock = SRWG_ARMED;
          end
        end
        SRWG_ARMED:
        begin
          next_lock = SRWG_LOCKED;
        end
        default:
        begin
          next_lock = SRWG_LOCKED;
        end
      endcase
    end
  end

  // Accept and error conditions; reads never touch them
  always_comb
  begin
    wr_ok = bus_wr && (cls == SRWG_CLS_PROT) && unlock_pending;
    err_set = 1'b0;
    if (bus_wr && (cls == SRWG_CLS_PROT) && !unlock_pending)
    begin
      err_set = 1'b1;
    end
    if (bus_wr && (cls != SRWG_CLS_PROT) && unlock_pending)
    begin
      err_set = 1'b1;
    end
    sys_clr = bus_wr && (cls == SRWG_CLS_SYS) &&
              bus_wmask[`SRWG_SYS_ERR_BIT] && !bus_wdata[`SRWG_SYS_ERR_BIT];
  end

  // Error flag: software clear takes precedence over its own set
  always_comb
  begin
    next_err = protection_error_flag;
    if (sys_clr)
    begin
      next_err = 1'b0;
    end
    else if (err_set)
    begin
      next_err = 1'b1;
    end
  end

  // Protected registers, bit or byte write through the mask
  always_comb
  begin
    for (int i = 0; i < PROT_NUM; i++)
    begin
      next_prot[i] = prot_q[i];
      if (wr_ok && (prot_idx == IDX_W'(i)))
      begin
        next_prot[i] = (prot_q[i] & ~bus_wmask) | (bus_wdata & bus_wmask);
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_comb
  begin
    next_rdata = '0;
    if (bus_rd)
    begin
      case (cls)
        SRWG_CLS_UNLOCK: next_rdata = `SRWG_UNLOCK_RD;
        SRWG_CLS_SYS: next_rdata = sys_value;
        SRWG_CLS_PROT: next_rdata = prot_q[prot_idx];
        SRWG_CLS_IRQS: next_rdata = `SRWG_DATA_W'(irq_stat);
        SRWG_CLS_IRQM: next_rdata = `SRWG_DATA_W'(irq_mask);
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      lock <= SRWG_LOCKED;
      protection_error_flag <= 1'b0;
      bus_rdata <= '0;
      for (int i = 0; i < PROT_NUM; i++)
      begin
        prot_q[i] <= `SRWG_PROT_RST;
      end
    end
    else
    begin
      lock <= next_lock;
      protection_error_flag <= next_err;
      bus_rdata <= next_rdata;
      for (int i = 0; i < PROT_NUM; i++)
      begin
        prot_q[i] <= next_prot[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < PROT_NUM; g++)
    begin : gen_flat
      assign prot_value[g*`SRWG_DATA_W +: `SRWG_DATA_W] = prot_q[g];
    end
  endgenerate

  // Event interrupts
  always_comb
  begin
    events = '0;
    events[`SRWG_EV_ERR] = err_set && !sys_clr;
    events[`SRWG_EV_OK] = wr_ok;
  end

  srwg_irq #(
    .EV_NUM(`SRWG_EV_NUM)
  ) u_irq (
    .clock(clock),
    .resetn(resetn),
    .event_in(events),
    .stat_wr(bus_wr && (cls == SRWG_CLS_IRQS)),
    .mask_wr(bus_wr && (cls == SRWG_CLS_IRQM)),
    .wdata(bus_wdata),
    .wmask(bus_wmask),
    .stat(irq_stat),
    .mask(irq_mask),
    .irq(irq)
  );

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  unlock_read_a: assert property (
    bus_rd && (cls == SRWG_CLS_UNLOCK) |=> bus_rdata == `SRWG_UNLOCK_RD)
    else $error("unlock read returned data");

  prot_keep_a: assert property (
    bus_wr && (cls == SRWG_CLS_PROT) && !unlock_pending
    |=> $stable(prot_value))
    else $error("protected register changed without unlock");

  prot_take_a: assert property (
    bus_wr && (cls == SRWG_CLS_PROT) && unlock_pending && (bus_wmask != '0)
    |=> prot_q[$past(prot_idx)] == $past(bus_wdata & bus_wmask |
        prot_q[prot_idx] & ~bus_wmask))
    else $error("protected write after unlock not taken");

  no_unlock_err_a: assert property (
    bus_wr && (cls == SRWG_CLS_PROT) && !unlock_pending
    |=> protection_error_flag)
    else $error("missing error on unguarded protected write");

  other_write_err_a: assert property (
    bus_wr && unlock_pending && (cls != SRWG_CLS_PROT) && !sys_clr
    |=> protection_error_flag)
    else $error("missing error on stray write after unlock");

  read_neutral_a: assert property (
    bus_rd && unlock_pending
    |=> unlock_pending && (protection_error_flag == $past(protection_error_flag)))
    else $error("read disturbed unlock or flag");

  flag_hold_a: assert property (
    protection_error_flag && !(bus_wr && (cls == SRWG_CLS_SYS))
    |=> protection_error_flag)
    else $error("error flag dropped without clear");

  clear_wins_a: assert property (
    unlock_pending && sys_clr |=> !protection_error_flag ##1
    (protection_error_flag == $past(err_set && !sys_clr)))
    else $error("flag clear after unlock lost");

  double_unlock_a: assert property (
    bus_wr && (cls == SRWG_CLS_UNLOCK) && unlock_pending
    |=> protection_error_flag && !unlock_pending)
    else $error("second unlock not flagged");

  sys_read_a: assert property (
    bus_rd && (cls == SRWG_CLS_SYS)
    |=> bus_rdata == {{(`SRWG_DATA_W-1){1'b0}}, $past(protection_error_flag)})
    else $error("status read mismatch");

  reset_state_a: assert property (
    @(posedge clock) disable iff (1'b0)
    !resetn |=> !protection_error_flag && !unlock_pending && (bus_rdata == '0))
    else $error("state not cleared by reset");

  int_hold_a: assert property (
    bus_wr && (cls == SRWG_CLS_UNLOCK) && !unlock_pending
    |=> int_hold)
    else $error("interrupts not held after unlock");

  hold_keep_a: assert property (
    int_hold && !bus_wr |=> int_hold)
    else $error("interrupt hold dropped before the store");

  consume_a: assert property (
    bus_wr && unlock_pending |=> !unlock_pending)
    else $error("unlock not consumed by write");

  unlock_arm_a: assert property (
    bus_wr && (cls == SRWG_CLS_UNLOCK) && !unlock_pending
    |=> unlock_pending)
    else $error("unlock write did not arm");

  flag_clear_a: assert property (
    sys_clr |=> !protection_error_flag)
    else $error("zero write did not clear error flag");

  set_ignore_a: assert property (
    bus_wr && (cls == SRWG_CLS_SYS) && !unlock_pending && !protection_error_flag
    |=> !protection_error_flag)
    else $error("status write raised the error flag");

  other_keep_a: assert property (
    bus_wr && (cls != SRWG_CLS_PROT) |=> $stable(prot_value))
    else $error("protected register changed by other write");

  ok_event_a: assert property (
    wr_ok |=> irq_stat[`SRWG_EV_OK])
    else $error("accepted write event missing");

  err_event_a: assert property (
    err_set && !sys_clr |=> irq_stat[`SRWG_EV_ERR])
    else $error("error event missing");

  rdata_idle_a: assert property (
    !bus_rd |=> bus_rdata == '0)
    else $error("read data outside the read cycle");

  guarded_store_c: cover property (
    bus_wr && (cls == SRWG_CLS_UNLOCK) ##1 bus_wr && (cls == SRWG_CLS_PROT));

  stray_store_c: cover property (
    bus_wr && unlock_pending && (cls == SRWG_CLS_OTHER));

  clear_after_unlock_c: cover property (
    unlock_pending && sys_clr);

  read_between_c: cover property (
    unlock_pending && bus_rd ##2 wr_ok);

  double_unlock_c: cover property (
    bus_wr && (cls == SRWG_CLS_UNLOCK) && unlock_pending);

endmodule

// ==== verilog/srwg_map.svh ====
// Purpose: Offsets, field positions, reset values for the write guard
// Assumes: 8-bit peripheral register port, byte-wide registers
// Notes: Protected slots 0..8 sit at consecutive offsets from PROT0
`ifndef SRWG_MAP_SVH
`define SRWG_MAP_SVH

`define SRWG_ADDR_W 8
`define SRWG_DATA_W 8

// Register offsets
`define SRWG_OFS_UNLOCK 8'h00
`define SRWG_OFS_SYS 8'h01
`define SRWG_OFS_IRQ_STAT 8'h02
`define SRWG_OFS_IRQ_MASK 8'h03
`define SRWG_OFS_PROT0 8'h10

// Protected slots: power save, clock, cpu clock, clock monitor,
// reset source, low voltage, debug mode, backup, subclock low power
`define SRWG_PROT_NUM 9

// Field positions
`define SRWG_SYS_ERR_BIT 0
`define SRWG_EV_ERR 0
`define SRWG_EV_OK 1
`define SRWG_EV_NUM 2

// Reset and read values
`define SRWG_SYS_RST 8'h00
`define SRWG_PROT_RST 8'h00
`define SRWG_UNLOCK_RD 8'h00
`define SRWG_IRQ_RST 8'h00

`endif

// ==== verilog/srwg_pkg.sv ====
// Purpose: Types shared by the write guard modules
// Assumes: Nothing beyond the map header
// Notes: Binary state codes written out
package srwg_pkg;

  typedef enum logic [2:0]
  {
    SRWG_CLS_UNLOCK = 3'b000,
    SRWG_CLS_SYS = 3'b001,
    SRWG_CLS_PROT = 3'b010,
    SRWG_CLS_IRQS = 3'b011,
    SRWG_CLS_IRQM = 3'b100,
    SRWG_CLS_OTHER = 3'b101
  } srwg_cls_e;

  typedef enum logic
  {
    SRWG_LOCKED = 1'b0,
    SRWG_ARMED = 1'b1
  } srwg_lock_e;

endpackage

// ==== verilog/srwg_irq.sv ====
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Single clock, synchronous active-low reset
// Notes: Write one clears; a new event beats the clear
`timescale 1ns/1ps
`include "srwg_map.svh"

module srwg_irq
  import srwg_pkg::*;
#(
  parameter int EV_NUM = `SRWG_EV_NUM
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [EV_NUM-1:0] event_in,
  input wire logic stat_wr,
  input wire logic mask_wr,
  input wire logic [`SRWG_DATA_W-1:0] wdata,
  input wire logic [`SRWG_DATA_W-1:0] wmask,
  output logic [EV_NUM-1:0] stat,
  output logic [EV_NUM-1:0] mask,
  output logic irq
);

  logic [EV_NUM-1:0] next_stat;
  logic [EV_NUM-1:0] next_mask;

  genvar g;
  generate
    for (g = 0; g < EV_NUM; g++)
    begin : gen_bit
      always_comb
      begin
        next_stat[g] = stat[g];
        if (stat_wr && wmask[g] && wdata[g])
        begin
          next_stat[g] = 1'b0;
        end
        if (event_in[g])
        begin
          next_stat[g] = 1'b1;
        end
        next_mask[g] = mask[g];
        if (mask_wr && wmask[g])
        begin
          next_mask[g] = wdata[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      stat <= EV_NUM'(`SRWG_IRQ_RST);
      mask <= EV_NUM'(`SRWG_IRQ_RST);
    end
    else
    begin
      stat <= next_stat;
      mask <= next_mask;
    end
  end

  assign irq = |(stat & mask);

endmodule

// ==== test/srwg_cpu_model.sv ====
// Purpose: CPU core model issuing peripheral stores and loads
// Assumes: One access per cycle, the guard never stalls
// Notes: Released address and data show inverted values
`timescale 1ns/1ps
`include "srwg_map.svh"

module srwg_cpu_model
(
  input wire logic clock,
  output logic [`SRWG_ADDR_W-1:0] bus_addr,
  output logic [`SRWG_DATA_W-1:0] bus_wdata,
  output logic [`SRWG_DATA_W-1:0] bus_wmask,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [`SRWG_DATA_W-1:0] bus_rdata
);
  initial
  begin
    bus_addr = 8'hFF;
    bus_wdata = 8'h00;
    bus_wmask = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wmask <= m;
    bus_wr <= 1'b1;
    bus_rd <= 1'b0;
  endtask

  task automatic idle();
    @(posedge clock);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clock);
    bus_addr <= a;
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    idle();
    q = bus_rdata;
  endtask

  // Unlock and target from the same data, consecutive stores
  task automatic guarded(input logic [7:0] a, input logic [7:0] d);
    wr(`SRWG_OFS_UNLOCK, d, 8'hFF);
    wr(a, d, 8'hFF);
  endtask
endmodule

// ==== test/srwg_guard_tb.sv ====
// Purpose: Self-checking bench of the special register write guard
// Assumes: CPU model drives the register port
// Notes: Each scenario judges its own outcome
`timescale 1ns/1ps
`include "srwg_map.svh"

module srwg_guard_tb;
  localparam logic [7:0] UL = `SRWG_OFS_UNLOCK;
  localparam logic [7:0] SY = `SRWG_OFS_SYS;
  localparam logic [7:0] IS = `SRWG_OFS_IRQ_STAT;
  localparam logic [7:0] IM = `SRWG_OFS_IRQ_MASK;
  localparam logic [7:0] P0 = `SRWG_OFS_PROT0;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_wmask;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata;
  logic [`SRWG_PROT_NUM*8-1:0] prot_value;
  logic protection_error_flag;
  logic unlock_pending;
  logic int_hold;
  logic irq;
  logic [7:0] q;
  int error_cnt = 0;
  int checks_done = 0;

  always #20 clock = ~clock;

  srwg_cpu_model cpu_i (.clock(clock), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wmask(bus_wmask), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  srwg_guard srwg_guard_i (.clock(clock), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wmask(bus_wmask), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .prot_value(prot_value),
    .protection_error_flag(protection_error_flag), .unlock_pending(unlock_pending),
    .int_hold(int_hold), .irq(irq));

  function automatic logic [7:0] slot(input int i);
    return prot_value[8*i +: 8];
  endfunction

  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic clr_flag();
    cpu_i.wr(SY, 8'h00, 8'h01);
    cpu_i.idle();
    check("flag", {7'h0, protection_error_flag}, 8'h00);
  endtask

  task automatic t_reset();
    check("pending", {7'h0, unlock_pending}, 8'h00);
    cpu_i.rd(SY, q);
    check("sys", q, 8'h00);
    cpu_i.rd(UL, q);
    check("unlock read", q, `SRWG_UNLOCK_RD);
    for (int i = 0; i < 9; i++)
      check("slot rst", slot(i), 8'h00);
  endtask

  task automatic t_guarded();
    for (int i = 0; i < 9; i++)
    begin
      cpu_i.guarded(P0 + 8'(i), 8'hA0 + 8'(i));
      #1;
      check("hold", {7'h0, int_hold}, 8'h01);
      cpu_i.idle();
      check("slot", slot(i), 8'hA0 + 8'(i));
      check("pending", {7'h0, unlock_pending}, 8'h00);
      check("hold off", {7'h0, int_hold}, 8'h00);
      check("flag", {7'h0, protection_error_flag}, 8'h00);
    end
  endtask

  task automatic t_nounlock();
    cpu_i.wr(P0 + 8'h01, 8'h55, 8'hFF);
    cpu_i.idle();
    check("slot1", slot(1), 8'hA1);
    check("flag", {7'h0, protection_error_flag}, 8'h01);
    cpu_i.rd(SY, q);
    check("sys", q, 8'h01);
    clr_flag();
  endtask

  task automatic t_other();
    cpu_i.wr(UL, 8'h00, 8'hFF);
    cpu_i.wr(8'h40, 8'h08, 8'h08);
    cpu_i.idle();
    check("flag", {7'h0, protection_error_flag}, 8'h01);
    check("pending", {7'h0, unlock_pending}, 8'h00);
    cpu_i.wr(P0 + 8'h02, 8'h5A, 8'hFF);
    cpu_i.idle();
    check("slot2", slot(2), 8'hA2);
    clr_flag();
  endtask

  task automatic t_reads();
    cpu_i.wr(UL, 8'h3C, 8'hFF);
    cpu_i.rd(SY, q);
    cpu_i.rd(8'h40, q);
    check("pending", {7'h0, unlock_pending}, 8'h01);
    cpu_i.wr(P0 + 8'h03, 8'h3C, 8'hFF);
    cpu_i.idle();
    check("slot3", slot(3), 8'h3C);
    check("flag", {7'h0, protection_error_flag}, 8'h00);
  endtask

  task automatic t_precedence();
    cpu_i.wr(P0, 8'h11, 8'hFF);
    cpu_i.wr(UL, 8'h00, 8'hFF);
    cpu_i.wr(SY, 8'h00, 8'h01);
    cpu_i.idle();
    check("flag", {7'h0, protection_error_flag}, 8'h00);
    check("pending", {7'h0, unlock_pending}, 8'h00);
  endtask

  task automatic t_double();
    cpu_i.wr(UL, 8'h77, 8'hFF);
    cpu_i.wr(UL, 8'h77, 8'hFF);
    cpu_i.wr(P0 + 8'h04, 8'h77, 8'hFF);
    #1;
    check("pending", {7'h0, unlock_pending}, 8'h00);
    check("flag", {7'h0, protection_error_flag}, 8'h01);
    cpu_i.idle();
    check("slot4", slot(4), 8'hA4);
    clr_flag();
  endtask

  task automatic t_irq();
    cpu_i.wr(IS, 8'h03, 8'hFF);
    cpu_i.wr(IM, 8'h01, 8'hFF);
    cpu_i.idle();
    check("irq off", {7'h0, irq}, 8'h00);
    cpu_i.wr(P0, 8'h22, 8'hFF);
    cpu_i.idle();
    check("irq on", {7'h0, irq}, 8'h01);
    cpu_i.wr(IM, 8'h00, 8'hFF);
    cpu_i.idle();
    check("irq masked", {7'h0, irq}, 8'h00);
    cpu_i.guarded(P0 + 8'h05, 8'h5E);
    cpu_i.idle();
    cpu_i.rd(IS, q);
    check("stat", q, 8'h03);
    cpu_i.wr(IS, 8'h03, 8'hFF);
    cpu_i.idle();
    cpu_i.rd(IS, q);
    check("stat clr", q, 8'h00);
    clr_flag();
  endtask

  task automatic t_midreset();
    cpu_i.wr(P0, 8'h33, 8'hFF);
    cpu_i.wr(UL, 8'h00, 8'hFF);
    cpu_i.idle();
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    #1;
    check("flag", {7'h0, protection_error_flag}, 8'h00);
    check("pending", {7'h0, unlock_pending}, 8'h00);
    check("slot0", slot(0), 8'h00);
    cpu_i.guarded(P0 + 8'h06, 8'h66);
    cpu_i.idle();
    check("slot6", slot(6), 8'h66);
    check("flag", {7'h0, protection_error_flag}, 8'h00);
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_guarded();
    t_nounlock();
    t_other();
    t_reads();
    t_precedence();
    t_double();
    t_irq();
    t_midreset();
    tally_and_finish();
  end
endmodule
